// File: hdl/pmc_pkg.sv
// Functional notes
// - Light-sleep bit halts core after instruction
// - Light sleep keeps state, peripherals running
// - Enabled interrupt clears light sleep, resumes
// - Reset in light sleep restarts at zero
// - Watchdog timeout resets out of light sleep
// - Deep-sleep bit stops oscillator, core, peripherals
// - Deep sleep: only missing-clock detector and pin reset active
// - Only resets end deep sleep
// - Missing-clock detector reset ends deep sleep
// - Regulator-off deep sleep: only pin reset
// - Both sleep select bits read zero
// - Upper six bits are plain flags
package pmc_pkg;
    localparam int          ADDR_W       = 8;
    localparam int          DATA_W       = 32;
    localparam logic [7:0]  PWR_CTRL_OFF = 8'h00;
    localparam logic [7:0]  REG_CTRL_OFF = 8'h04;
    localparam logic [7:0]  STATUS_OFF   = 8'h08;
    localparam int          LIGHT_BIT    = 0;
    localparam int          DEEP_BIT     = 1;
    localparam int          GF_LSB       = 2;
    localparam int          GF_MSB       = 7;
    localparam int          GF_W         = 6;
    localparam int          REG_STOP_BIT = 0;
    localparam logic [5:0]  GF_RST       = 6'h00;
    localparam logic [1:0]  HTRANS_NSEQ  = 2'h2;
    localparam logic        HRESP_OKAY   = 1'b0;
    localparam logic [15:0] RESET_ADDR   = 16'h0000;
    localparam logic [31:0] RDATA_ZERO   = 32'h0000_0000;

    typedef enum logic [2:0] {
        ST_RUN   = 3'b001,
        ST_LIGHT = 3'b010,
        ST_DEEP  = 3'b100
    } pmc_state_t;
endpackage : pmc_pkg

// File: hdl/pmc_sync.sv
`timescale 1ns/1ps
module pmc_sync #(
    parameter int         W      = 1,
    parameter logic [W-1:0] INIT = '0
) (
    // Clock and reset
    input  wire logic         clk_sys,
    input  wire logic         rst,
    // Data
    input  wire logic [W-1:0] d,
    output logic      [W-1:0] q
);
    logic [W-1:0] meta_q;

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            meta_q <= INIT;
            q      <= INIT;
        end else begin
            meta_q <= d;
            q      <= meta_q;
        end
    end
endmodule : pmc_sync

// File: hdl/pmc_power_mode_controller.sv
`timescale 1ns/1ps
module pmc_power_mode_controller (
    // Clock and reset
    input  wire logic                       clk_sys,
    input  wire logic                       rst,
    // AHB-Lite slave
    input  wire logic                       hsel,
    input  wire logic [pmc_pkg::ADDR_W-1:0] haddr,
    input  wire logic [1:0]                 htrans,
    input  wire logic                       hwrite,
    input  wire logic [2:0]                 hsize,
    input  wire logic [pmc_pkg::DATA_W-1:0] hwdata,
    input  wire logic                       hready,
    output logic                            hreadyout,
    output logic                            hresp,
    output logic      [pmc_pkg::DATA_W-1:0] hrdata,
    // Core side
    input  wire logic                       instrDone,
    input  wire logic                       irqPending,
    input  wire logic                       wdtTimeout,
    input  wire logic                       mcdEnable,
    // Pins and analog sources
    input  wire logic                       mcdTimeout,
    input  wire logic                       extResetN,
    // Power controls
    output logic                            cpuHalt,
    output logic                            periphClkEn,
    output logic                            intOscEn,
    output logic                            irqTimerEn,
    output logic                            regulatorEn,
    output logic                            resetReq,
    output logic      [15:0]                resetAddr
);
    pmc_pkg::pmc_state_t state_q;
    pmc_pkg::pmc_state_t state_d;

    logic                     wrPhase_q;
    logic [7:0]               wrAddr_q;
    logic [pmc_pkg::GF_W-1:0] genFlags_q;
    logic                     regStop_q;
    logic                     regOff_q;
    logic                     pendLight_q;
    logic                     pendDeep_q;
    logic                     resetReq_q;
    logic                     rdPhase_q;
    logic [7:0]               rdAddr_q;
    logic [1:0]               syncOut;
    logic                     mcdSync;
    logic                     extRstSync;
    logic                     addrPhase;
    logic                     wrPwr;
    logic                     wrLight;
    logic                     wrDeep;
    logic                     wantLight;
    logic                     wantDeep;
    logic                     wdtHit;
    logic                     mcdHit;
    logic                     pinHit;

    pmc_sync #(
        .W    (2),
        .INIT (2'h2)
    ) u_sync (
        .clk_sys (clk_sys),
        .rst     (rst),
        .d       ({extResetN, mcdTimeout}),
        .q       (syncOut)
    );

    assign mcdSync    = syncOut[0];
    assign extRstSync = syncOut[1];

    // Bus decode
    assign addrPhase = hsel && hready && (htrans == pmc_pkg::HTRANS_NSEQ);
    assign wrPwr     = wrPhase_q && (wrAddr_q == pmc_pkg::PWR_CTRL_OFF);
    assign wrLight   = wrPwr && hwdata[pmc_pkg::LIGHT_BIT];
    assign wrDeep    = wrPwr && hwdata[pmc_pkg::DEEP_BIT];
    assign hreadyout = 1'b1;
    assign hresp     = pmc_pkg::HRESP_OKAY;

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            wrPhase_q <= 1'b0;
            rdPhase_q <= 1'b0;
            wrAddr_q  <= '0;
            rdAddr_q  <= '0;
        end else begin
            wrPhase_q <= addrPhase && hwrite;
            rdPhase_q <= addrPhase && !hwrite;
            if (addrPhase) begin
                wrAddr_q <= haddr;
                rdAddr_q <= haddr;
            end
        end
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            genFlags_q <= pmc_pkg::GF_RST;
        end else if (wrPwr) begin
            genFlags_q <= hwdata[pmc_pkg::GF_MSB:pmc_pkg::GF_LSB];
        end
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            regStop_q <= 1'b0;
        end else if (wrPhase_q && wrAddr_q == pmc_pkg::REG_CTRL_OFF) begin
            regStop_q <= hwdata[pmc_pkg::REG_STOP_BIT];
        end
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            hrdata <= pmc_pkg::RDATA_ZERO;
        end else if (addrPhase && !hwrite) begin
            case (haddr)
                pmc_pkg::PWR_CTRL_OFF:
                    hrdata <= {24'h0000_00, genFlags_q, 2'h0};
                pmc_pkg::REG_CTRL_OFF:
                    hrdata <= {31'h0000_0000, regStop_q};
                pmc_pkg::STATUS_OFF:
                    hrdata <= {24'h0000_00, regOff_q, resetReq_q,
                               pendDeep_q, pendLight_q, 1'b0, state_q};
                default:
                    hrdata <= pmc_pkg::RDATA_ZERO;
            endcase
        end
    end

    // Pending selects wait for instruction end
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            pendLight_q <= 1'b0;
            pendDeep_q  <= 1'b0;
        end else if (instrDone) begin
            pendLight_q <= 1'b0;
            pendDeep_q  <= 1'b0;
        end else begin
            pendLight_q <= pendLight_q | wrLight;
            pendDeep_q  <= pendDeep_q | wrDeep;
        end
    end

    assign wantLight = instrDone && (pendLight_q || wrLight);
    assign wantDeep  = instrDone && (pendDeep_q || wrDeep);

    always_comb begin
        state_d = state_q;
        case (state_q)
            pmc_pkg::ST_RUN: begin
                if (wantDeep) begin
                    state_d = pmc_pkg::ST_DEEP;
                end else if (wantLight) begin
                    state_d = pmc_pkg::ST_LIGHT;
                end
            end
            pmc_pkg::ST_LIGHT: begin
                if (irqPending && !resetReq_q) begin
                    state_d = pmc_pkg::ST_RUN;
                end
            end
            pmc_pkg::ST_DEEP: state_d = pmc_pkg::ST_DEEP;
            default:          state_d = pmc_pkg::ST_RUN;
        endcase
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            state_q <= pmc_pkg::ST_RUN;
        end else begin
            state_q <= state_d;
        end
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            regOff_q <= 1'b0;
        end else if (state_q == pmc_pkg::ST_RUN && wantDeep) begin
            regOff_q <= regStop_q;
        end
    end

    assign wdtHit = wdtTimeout && (state_q != pmc_pkg::ST_DEEP);
    assign mcdHit = mcdSync && mcdEnable
                 && !(state_q == pmc_pkg::ST_DEEP && regOff_q);
    assign pinHit = !extRstSync;

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            resetReq_q <= 1'b0;
        end else if (wdtHit || mcdHit || pinHit) begin
            resetReq_q <= 1'b1;
        end
    end

    // nothing cleared by sleep; only clocks, events and regulator gated
    assign cpuHalt     = (state_q != pmc_pkg::ST_RUN);
    // deep sleep gates clocks and events
    assign periphClkEn = (state_q != pmc_pkg::ST_DEEP);
    assign intOscEn    = (state_q != pmc_pkg::ST_DEEP);
    assign irqTimerEn  = (state_q != pmc_pkg::ST_DEEP);
    assign regulatorEn = !(state_q == pmc_pkg::ST_DEEP && regOff_q);
    assign resetReq    = resetReq_q;
    assign resetAddr   = pmc_pkg::RESET_ADDR;

    logic unusedSize;
    assign unusedSize = |hsize;

    a_light_entry: assert property (
        @(posedge clk_sys) disable iff (rst)
        state_q == pmc_pkg::ST_RUN && wantLight && !wantDeep
        |=> state_q == pmc_pkg::ST_LIGHT)
        else $error("light sleep not entered");

    a_pend_clear: assert property (
        @(posedge clk_sys) disable iff (rst)
        instrDone |=> !pendLight_q && !pendDeep_q)
        else $error("pending select not cleared");

    a_light_halts: assert property (
        @(posedge clk_sys) disable iff (rst)
        state_q == pmc_pkg::ST_LIGHT
        |-> cpuHalt && periphClkEn && intOscEn && irqTimerEn)
        else $error("light sleep gating wrong");

    a_run_awake: assert property (
        @(posedge clk_sys) disable iff (rst)
        state_q == pmc_pkg::ST_RUN |-> !cpuHalt && periphClkEn
            && intOscEn && irqTimerEn && regulatorEn)
        else $error("run mode gating wrong");

    a_irq_wake: assert property (
        @(posedge clk_sys) disable iff (rst)
        state_q == pmc_pkg::ST_LIGHT && irqPending && !resetReq_q
        |=> state_q == pmc_pkg::ST_RUN && !cpuHalt)
        else $error("interrupt did not wake");

    a_light_stays: assert property (
        @(posedge clk_sys) disable iff (rst)
        state_q == pmc_pkg::ST_LIGHT && !irqPending
        |=> state_q == pmc_pkg::ST_LIGHT)
        else $error("light sleep left without interrupt");

    a_light_reset: assert property (
        @(posedge clk_sys) disable iff (rst)
        state_q == pmc_pkg::ST_LIGHT && pinHit
        |=> resetReq && resetAddr == pmc_pkg::RESET_ADDR)
        else $error("pin reset not raised");

    a_req_sticky: assert property (
        @(posedge clk_sys) disable iff (rst)
        resetReq |=> resetReq)
        else $error("reset request dropped");

    a_wdt_reset: assert property (
        @(posedge clk_sys) disable iff (rst)
        state_q == pmc_pkg::ST_LIGHT && wdtTimeout |=> resetReq)
        else $error("watchdog reset missing");

    a_deep_entry: assert property (
        @(posedge clk_sys) disable iff (rst)
        state_q == pmc_pkg::ST_RUN && wantDeep
        |=> state_q == pmc_pkg::ST_DEEP && !intOscEn
            && !periphClkEn && regulatorEn == !$past(regStop_q))
        else $error("deep sleep entry wrong");

    a_deep_quiet: assert property (
        @(posedge clk_sys) disable iff (rst)
        state_q == pmc_pkg::ST_DEEP && wdtTimeout && extRstSync
        && !mcdSync && !resetReq_q |=> !resetReq)
        else $error("watchdog active in deep sleep");

    a_deep_gates: assert property (
        @(posedge clk_sys) disable iff (rst)
        state_q == pmc_pkg::ST_DEEP |-> cpuHalt && !periphClkEn
            && !intOscEn && !irqTimerEn)
        else $error("deep sleep gating wrong");

    a_deep_holds: assert property (
        @(posedge clk_sys) disable iff (rst)
        state_q == pmc_pkg::ST_DEEP && irqPending
        |=> state_q == pmc_pkg::ST_DEEP)
        else $error("interrupt left deep sleep");

    a_mcd_reset: assert property (
        @(posedge clk_sys) disable iff (rst)
        state_q == pmc_pkg::ST_DEEP && !regOff_q && mcdSync
        && mcdEnable |=> resetReq)
        else $error("detector reset missing");

    a_mcd_disabled: assert property (
        @(posedge clk_sys) disable iff (rst)
        mcdSync && !mcdEnable && extRstSync && !wdtTimeout
        && !resetReq_q |=> !resetReq)
        else $error("disabled detector raised reset");

    a_regoff_pin: assert property (
        @(posedge clk_sys) disable iff (rst)
        state_q == pmc_pkg::ST_DEEP && regOff_q && extRstSync
        && !resetReq_q |=> !resetReq && !regulatorEn)
        else $error("reset despite regulator off");

    a_pin_always: assert property (
        @(posedge clk_sys) disable iff (rst)
        pinHit |=> resetReq)
        else $error("pin reset ignored");

    a_regoff_latch: assert property (
        @(posedge clk_sys) disable iff (rst)
        state_q == pmc_pkg::ST_RUN && wantDeep
        |=> regOff_q == $past(regStop_q))
        else $error("regulator choice not latched");

    a_sel_readzero: assert property (
        @(posedge clk_sys) disable iff (rst)
        rdPhase_q && rdAddr_q == pmc_pkg::PWR_CTRL_OFF
        |-> hrdata[1:0] == 2'h0)
        else $error("select bits read nonzero");

    a_flags_store: assert property (
        @(posedge clk_sys) disable iff (rst)
        wrPwr |=> genFlags_q
            == $past(hwdata[pmc_pkg::GF_MSB:pmc_pkg::GF_LSB]))
        else $error("flags not stored");

    a_both_deep: assert property (
        @(posedge clk_sys) disable iff (rst)
        state_q == pmc_pkg::ST_RUN && wantDeep && wantLight
        |=> state_q == pmc_pkg::ST_DEEP)
        else $error("both bits did not give deep");

    c_light_wake: cover property (@(posedge clk_sys) disable iff (rst)
        state_q == pmc_pkg::ST_LIGHT ##1 state_q == pmc_pkg::ST_RUN);
    c_deep_mcd: cover property (@(posedge clk_sys) disable iff (rst)
        state_q == pmc_pkg::ST_DEEP && resetReq);
    c_deep_regoff: cover property (@(posedge clk_sys) disable iff (rst)
        state_q == pmc_pkg::ST_DEEP && !regulatorEn);
    c_wdt_light: cover property (@(posedge clk_sys) disable iff (rst)
        state_q == pmc_pkg::ST_LIGHT && wdtTimeout);
    c_both_bits: cover property (@(posedge clk_sys) disable iff (rst)
        state_q == pmc_pkg::ST_RUN && wantDeep && wantLight);
endmodule : pmc_power_mode_controller

// File: verification/pmc_power_mode_controller_bench.sv
`timescale 1ns/1ps
module pmc_power_mode_controller_bench;
    logic                        clk_sys     = 1'b0;
    logic                        rst         = 1'b1;
    logic                        hsel        = 1'b0;
    logic [pmc_pkg::ADDR_W-1:0]  haddr       = '0;
    logic [1:0]                  htrans      = 2'h0;
    logic                        hwrite      = 1'b0;
    logic [2:0]                  hsize       = 3'h2;
    logic [pmc_pkg::DATA_W-1:0]  hwdata      = '0;
    logic                        instrDone   = 1'b0;
    logic                        irqPending  = 1'b0;
    logic                        wdtTimeout  = 1'b0;
    logic                        mcdEnable   = 1'b0;
    logic                        mcdTimeout  = 1'b0;
    logic                        extResetN   = 1'b1;
    logic                        hreadyout;
    logic                        hresp;
    logic [pmc_pkg::DATA_W-1:0]  hrdata;
    logic                        cpuHalt;
    logic                        periphClkEn;
    logic                        intOscEn;
    logic                        irqTimerEn;
    logic                        regulatorEn;
    logic                        resetReq;
    logic [15:0]                 resetAddr;
    logic [31:0]                 rd;
    logic [31:0]                 seed        = 32'hb7bd_3b6f;
    logic [31:0]                 gf;
    int                          errCount    = 0;
    int                          nChecks     = 0;

    pmc_power_mode_controller pmc_power_mode_controller_i (
        .clk_sys(clk_sys), .rst(rst), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
        .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp),
        .hrdata(hrdata), .instrDone(instrDone), .irqPending(irqPending),
        .wdtTimeout(wdtTimeout), .mcdEnable(mcdEnable),
        .mcdTimeout(mcdTimeout), .extResetN(extResetN), .cpuHalt(cpuHalt),
        .periphClkEn(periphClkEn), .intOscEn(intOscEn),
        .irqTimerEn(irqTimerEn), .regulatorEn(regulatorEn),
        .resetReq(resetReq), .resetAddr(resetAddr)
    );

    always #5 clk_sys = ~clk_sys;

    function automatic logic [31:0] xorshift(input logic [31:0] s);
        s = s ^ (s << 13);
        s = s ^ (s >> 17);
        s = s ^ (s << 5);
        return s;
    endfunction : xorshift

    // Expected status word
    function automatic logic [31:0] stat(input logic [2:0] st,
        input logic [1:0] pend, input logic rr, input logic ro);
        return {24'h00_0000, ro, rr, pend, 1'b0, st};
    endfunction : stat

    task automatic finish_test;
        $display("checks %0d mismatches %0d", nChecks, errCount);
        if (errCount == 0 && nChecks > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask : finish_test

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        nChecks++;
        if (seen !== exp) begin
            errCount++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check

    task automatic bus(input logic wr, input logic [7:0] a,
        input logic [31:0] d);
        @(posedge clk_sys);
        hsel   <= 1'b1;
        htrans <= pmc_pkg::HTRANS_NSEQ;
        haddr  <= a;
        hwrite <= wr;
        hsize  <= 3'h2;
        do @(posedge clk_sys); while (hreadyout !== 1'b1);
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge clk_sys); while (hreadyout !== 1'b1);
        rd = hrdata;
        check(hresp, pmc_pkg::HRESP_OKAY); // bus answers okay
        check(hreadyout, 1'b1); // slave never waits
    endtask : bus

    task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
        bus(1'b0, a, 32'h0000_0000);
        check(rd, exp); // register readback
    endtask : rdchk

    task automatic pulse_done;
        instrDone <= 1'b1;
        @(posedge clk_sys);
        instrDone <= 1'b0;
        #1;
    endtask : pulse_done

    task automatic reset_pulse;
        rst <= 1'b1;
        repeat (2) @(posedge clk_sys);
        rst <= 1'b0;
    endtask : reset_pulse

    task automatic wait_req;
        for (int i = 0; i < 8 && resetReq !== 1'b1; i++) @(posedge clk_sys);
        #1;
    endtask : wait_req

    // Sleep outputs: halt, periph clock, osc, irq/timer, regulator
    function automatic logic [31:0] outs();
        return {27'h000_0000, cpuHalt, periphClkEn, intOscEn, irqTimerEn,
                regulatorEn};
    endfunction : outs

    initial begin
        repeat (3000) @(posedge clk_sys);
        errCount++;
        finish_test();
    end

    initial begin
        repeat (10) @(posedge clk_sys);
        rst <= 1'b0;
        #1;
        check(outs(), 32'h0000_000F); // awake after reset
        check(resetAddr, pmc_pkg::RESET_ADDR); // fetch address
        rdchk(pmc_pkg::STATUS_OFF, stat(3'h1, 2'h0, 1'b0, 1'b0)); // run
        $display("test reset done");
        for (int i = 0; i < 8; i++) begin
            seed = xorshift(seed);
            gf   = seed & 32'h0000_00FC;
            // Selects masked: no stale pending entry
            bus(1'b1, pmc_pkg::PWR_CTRL_OFF, seed & 32'hFFFF_FFFC);
            rdchk(pmc_pkg::PWR_CTRL_OFF, gf); // flags stored
        end
        bus(1'b1, 8'h0C, 32'h0000_00FF);
        rdchk(8'h0C, 32'h0000_0000); // unmapped reads zero
        rdchk(pmc_pkg::PWR_CTRL_OFF, gf); // unmapped write ignored
        $display("test flags done");
        bus(1'b1, pmc_pkg::PWR_CTRL_OFF, 32'h0000_0001 | gf);
        pulse_done();
        check(outs(), 32'h0000_001F); // core halted, rest on
        rdchk(pmc_pkg::STATUS_OFF, stat(3'h2, 2'h0, 1'b0, 1'b0)); // light
        rdchk(pmc_pkg::PWR_CTRL_OFF, gf); // kept, select reads 0
        irqPending <= 1'b1;
        @(posedge clk_sys);
        irqPending <= 1'b0;
        #1;
        check(cpuHalt, 1'b0); // interrupt wakes
        pulse_done();
        check(cpuHalt, 1'b0); // nothing pending stays awake
        $display("test light done");
        bus(1'b1, pmc_pkg::PWR_CTRL_OFF, 32'h0000_0001);
        pulse_done();
        mcdTimeout <= 1'b1;
        repeat (6) @(posedge clk_sys);
        #1;
        check(resetReq, 1'b0); // disabled detector ignored
        mcdTimeout <= 1'b0;
        extResetN  <= 1'b0;
        wait_req();
        check(resetReq, 1'b1); // pin reset ends light sleep
        check(cpuHalt, 1'b1); // halted until reset applied
        extResetN <= 1'b1;
        reset_pulse();
        #1;
        check(outs(), 32'h0000_000F); // running after reset
        $display("test light reset done");
        bus(1'b1, pmc_pkg::PWR_CTRL_OFF, 32'h0000_0001);
        pulse_done();
        wdtTimeout <= 1'b1;
        @(posedge clk_sys);
        wdtTimeout <= 1'b0;
        #1;
        check(resetReq, 1'b1); // watchdog ends light sleep
        check(resetAddr, pmc_pkg::RESET_ADDR); // restart address
        reset_pulse();
        #1;
        check(outs(), 32'h0000_000F); // running after reset
        $display("test watchdog done");
        mcdEnable <= 1'b1;
        bus(1'b1, pmc_pkg::PWR_CTRL_OFF, 32'h0000_0002);
        pulse_done();
        check(outs(), 32'h0000_0011); // deep stops clocks
        irqPending <= 1'b1;
        wdtTimeout <= 1'b1;
        repeat (4) @(posedge clk_sys);
        irqPending <= 1'b0;
        wdtTimeout <= 1'b0;
        #1;
        check({cpuHalt, resetReq}, 32'h0000_0002); // no wake
        mcdTimeout <= 1'b1;
        wait_req();
        check(resetReq, 1'b1); // detector resets deep
        mcdTimeout <= 1'b0;
        reset_pulse();
        $display("test deep done");
        bus(1'b1, pmc_pkg::PWR_CTRL_OFF, 32'h0000_00FF);
        rdchk(pmc_pkg::PWR_CTRL_OFF, 32'h0000_00FC); // selects read 0
        rdchk(pmc_pkg::STATUS_OFF, stat(3'h1, 2'h3, 1'b0, 1'b0));
        pulse_done();
        check(outs(), 32'h0000_0011); // deep wins
        reset_pulse();
        $display("test both done");
        bus(1'b1, pmc_pkg::REG_CTRL_OFF, 32'h0000_0001);
        rdchk(pmc_pkg::REG_CTRL_OFF, 32'h0000_0001); // stop bit set
        bus(1'b1, pmc_pkg::PWR_CTRL_OFF, 32'h0000_0002);
        pulse_done();
        check(regulatorEn, 1'b0); // regulator off in deep
        rdchk(pmc_pkg::STATUS_OFF, stat(3'h4, 2'h0, 1'b0, 1'b1));
        mcdTimeout <= 1'b1;
        repeat (6) @(posedge clk_sys);
        #1;
        check(resetReq, 1'b0); // detector cannot reset
        mcdTimeout <= 1'b0;
        extResetN  <= 1'b0;
        wait_req();
        check(resetReq, 1'b1); // pin reset still works
        extResetN <= 1'b1;
        reset_pulse();
        #1;
        check(regulatorEn, 1'b1); // regulator back on
        $display("test regulator done");
        finish_test();
    end
endmodule : pmc_power_mode_controller_bench
